/* File: verilog/sbi_pkg.sv */
package sbi_pkg;
  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] SBI_OFF_ENABLE = 8'h00;
  localparam logic [7:0] SBI_OFF_XFER = 8'h04;
  localparam logic [7:0] SBI_OFF_DATA = 8'h08;
  localparam logic [7:0] SBI_OFF_ADDR = 8'h0C;
  localparam logic [7:0] SBI_OFF_CMDSTAT = 8'h10;
  localparam logic [7:0] SBI_OFF_BAUD = 8'h14;

  // ==========================================================
  // Field positions
  localparam int SBI_EN_BIT = 7;
  localparam int SBI_LEN_LSB = 5;
  localparam int SBI_ACK_BIT = 4;
  localparam int SBI_ONE_BIT = 3;
  localparam int SBI_SCK_LSB = 1;
  localparam int SBI_SOFT_RESET_MONITOR_BIT = 0;
  localparam int SBI_MST_BIT = 7;
  localparam int SBI_TRX_BIT = 6;
  localparam int SBI_BUSY_BIT = 5;
  localparam int SBI_MODE_LSB = 2;

  // ==========================================================
  // Codes and reset values
  localparam logic [1:0] SBI_MODE_PORT = 2'h0;
  localparam logic [1:0] SBI_MODE_SIO = 2'h1;
  localparam logic [1:0] SBI_MODE_I2C = 2'h2;
  localparam logic [1:0] SBI_MODE_RSVD = 2'h3;
  localparam logic [2:0] SBI_LEN_FULL = 3'h0;
  localparam logic [3:0] SBI_FULL_BITS = 4'h8;
  localparam logic [31:0] SBI_ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] SBI_STRB_FULL = 4'hF;
  localparam logic [1:0] SBI_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBI_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SBI_XF_IDLE = 2'b00,
    SBI_XF_BUSY = 2'b01
  } sbi_xfer_type;

  // Clock pulses for one transfer: length plus optional acknowledge slot
  function automatic logic [3:0] sbi_clocks(input logic [2:0] len, input logic ack);
    logic [3:0] bits;
    bits = (len == SBI_LEN_FULL) ? SBI_FULL_BITS : {1'b0, len};
    sbi_clocks = bits + {3'h0, ack};
  endfunction : sbi_clocks
endpackage : sbi_pkg

/* File: verilog/sbi_sync.sv */
module sbi_sync import sbi_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ==========================================================
  // Two-stage level synchroniser; first stage feeds only the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } sbi_sync_type;

  sbi_sync_type s;
  sbi_sync_type next_s;

  always_comb begin
    next_s.meta = async_in;
    next_s.out = s.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.out;
endmodule : sbi_sync

/* File: verilog/sbi_link.sv */
module sbi_link import sbi_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic start_toggle,
  input wire logic run,
  input wire logic [DATA_W-1:0] tx_word,
  input wire logic [3:0] clock_count,
  input wire logic ack_slot,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_active,
  output logic done_toggle,
  output logic [DATA_W-1:0] rx_word
);
  // ==========================================================
  // Link-side shifter; tx_word is held stable by the register side from the
  // start toggle until the done toggle returns; clock_count is read only at the start
  typedef struct packed {
    logic start_seen;
    logic active;
    logic [3:0] left;
    logic [DATA_W-1:0] shift;
    logic out;
    logic done;
  } sbi_link_type;

  sbi_link_type s;
  sbi_link_type next_s;
  logic [2:0] synced;

  sbi_sync #(.WIDTH(3)) u_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .async_in({start_toggle, run, serial_in}),
    .sync_out(synced)
  );

  always_comb begin
    next_s = s;
    next_s.start_seen = synced[2];
    if (!synced[1]) begin
      next_s.active = 1'b0; // RL4
    end else if (!s.active && (synced[2] != s.start_seen)) begin
      next_s.active = 1'b1;
      next_s.left = clock_count; // RL7
      next_s.shift = tx_word;
      // First bit leaves with the active flag, so every active cycle carries a bit
      next_s.out = tx_word[DATA_W-1];
    end else if (s.active) begin
      // The acknowledge slot clocks the line but moves no data bit
      if (!(ack_slot && (s.left == 4'h1))) begin
        next_s.shift = {s.shift[DATA_W-2:0], synced[0]};
      end
      // The last bit stays on the line after the frame
      if (s.left != 4'h1) begin
        next_s.out = next_s.shift[DATA_W-1];
      end
      next_s.left = s.left - 4'h1;
      if (s.left == 4'h1) begin
        next_s.active = 1'b0;
        next_s.done = ~s.done;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign serial_out = s.out;
  assign serial_active = s.active;
  assign done_toggle = s.done;
  assign rx_word = s.shift;
endmodule : sbi_link

/* File: verilog/sbi_regs.sv */
// Operation
// [RL1] Two modes: bus mode and 8-bit clocked serial
// [RL2] Enable is bit 7, resets 0, rest zero
// [RL3] Other registers usable only after enable set
// [RL4] Disabled: everything but enable register stops
// [RL5] Disabling keeps every register's contents
// [RL6] Fixed map; command writes, status reads share 0x10
// [RL7] Length field 7-5; ack adds one clock
// [RL8] Monitor bit reads 1; clock select starts 0
// [RL9] Mode 00 port, 01 serial, 10 bus, 11 reserved
// [RL10] Full words; reserved bits read zero, ignore writes
module sbi_regs import sbi_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_active,
  output logic interface_clock_run
);
  // ==========================================================
  // State
  typedef struct packed {
    logic awready;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic enable;
    logic [2:0] len;
    logic ack;
    logic [1:0] sck_hi;
    logic sck0;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] own_addr;
    logic [7:0] baud;
    logic mst;
    logic trx;
    logic [1:0] mode;
    sbi_xfer_type xfer;
    logic start_toggle;
    logic done_seen;
  } sbi_regs_type;

  sbi_regs_type s;
  sbi_regs_type next_s;
  logic done_sync;
  logic done_toggle;
  logic [7:0] link_rx;

  // ==========================================================
  // Register select; one decode feeds the read, write and response paths
  typedef enum logic [2:0] {
    SBI_SEL_NONE = 3'h0,
    SBI_SEL_ENABLE = 3'h1,
    SBI_SEL_XFER = 3'h3,
    SBI_SEL_DATA = 3'h2,
    SBI_SEL_ADDR = 3'h6,
    SBI_SEL_CMDSTAT = 3'h7,
    SBI_SEL_BAUD = 3'h5
  } sbi_sel_type;

  function automatic sbi_sel_type sbi_select(input logic [ADDR_W-1:0] a);
    sbi_sel_type sel;
    sel = SBI_SEL_NONE;
    if (a == ADDR_W'(SBI_OFF_ENABLE)) begin
      sel = SBI_SEL_ENABLE;
    end else if (a == ADDR_W'(SBI_OFF_XFER)) begin
      sel = SBI_SEL_XFER;
    end else if (a == ADDR_W'(SBI_OFF_DATA)) begin
      sel = SBI_SEL_DATA;
    end else if (a == ADDR_W'(SBI_OFF_ADDR)) begin
      sel = SBI_SEL_ADDR;
    end else if (a == ADDR_W'(SBI_OFF_CMDSTAT)) begin
      sel = SBI_SEL_CMDSTAT;
    end else if (a == ADDR_W'(SBI_OFF_BAUD)) begin
      sel = SBI_SEL_BAUD; // RL6
    end
    sbi_select = sel;
  endfunction : sbi_select

  // Byte lanes are never merged, so only whole-word offsets decode
  function automatic logic sbi_mapped(input logic [ADDR_W-1:0] a);
    sbi_mapped = (sbi_select(a) != SBI_SEL_NONE); // RL6
  endfunction : sbi_mapped

  // ==========================================================
  // Read data; registers behind the enable read zero while stopped
  function automatic logic [31:0] sbi_read(input sbi_regs_type r, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    sbi_sel_type sel;
    v = SBI_ZERO_WORD; // RL10
    sel = sbi_select(a);
    if (sel == SBI_SEL_ENABLE) begin
      v[SBI_EN_BIT] = r.enable; // RL2
    end else if (r.enable) begin // RL3
      unique case (sel)
        SBI_SEL_XFER: begin
          v[SBI_LEN_LSB +: 3] = r.len;
          v[SBI_ACK_BIT] = r.ack;
          v[SBI_ONE_BIT] = 1'b1;
          v[SBI_SCK_LSB +: 2] = r.sck_hi;
          // No software reset in progress, so the monitor always shows 1
          v[SBI_SOFT_RESET_MONITOR_BIT] = 1'b1; // RL8
        end
        SBI_SEL_DATA: begin
          v[7:0] = r.rx_data;
        end
        SBI_SEL_ADDR: begin
          v[7:0] = r.own_addr;
        end
        SBI_SEL_CMDSTAT: begin
          v[SBI_MST_BIT] = r.mst; // RL6
          v[SBI_TRX_BIT] = r.trx;
          v[SBI_BUSY_BIT] = (r.xfer == SBI_XF_BUSY);
          v[SBI_MODE_LSB +: 2] = r.mode;
        end
        SBI_SEL_BAUD: begin
          v[7:0] = r.baud;
        end
        default: begin
          v = SBI_ZERO_WORD;
        end
      endcase
    end
    sbi_read = v;
  endfunction : sbi_read

  // ==========================================================
  // Link side and its crossing
  sbi_link #(.DATA_W(8)) u_link (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .start_toggle(s.start_toggle),
    .run(s.enable),
    .tx_word(s.tx_data),
    .clock_count(sbi_clocks(s.len, s.ack)),
    .ack_slot(s.ack),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_active(serial_active),
    .done_toggle(done_toggle),
    .rx_word(link_rx)
  );

  sbi_sync #(.WIDTH(1)) u_done_sync (
    .clk(mclk),
    .reset_n(reset_n),
    .async_in(done_toggle),
    .sync_out(done_sync)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic do_write;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    sbi_sel_type wsel;
    do_write = 1'b0;
    wsel = sbi_select(s.aw_addr);
    wa = s.aw_addr;
    wd = s.w_data;
    next_s = s;
    next_s.done_seen = done_sync;

    // Write address and data are taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      // Strobes are kept with the data; the master may move on once taken
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_full && s.w_full && !s.bvalid) begin
      do_write = 1'b1;
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      // Partial-word writes are refused rather than merged
      next_s.bresp = (sbi_mapped(wa) && (s.w_strb == SBI_STRB_FULL)) ?
                     SBI_RESP_OKAY : SBI_RESP_SLVERR; // RL10
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;

    // Transfer completion crosses back as a toggle; rx word is stable by then
    if ((s.xfer == SBI_XF_BUSY) && (done_sync != s.done_seen)) begin
      next_s.xfer = SBI_XF_IDLE;
      next_s.rx_data = link_rx;
    end

    // A disabled block holds every register except the enable itself
    if (do_write && (s.w_strb == SBI_STRB_FULL)) begin
      if (wsel == SBI_SEL_ENABLE) begin
        next_s.enable = wd[SBI_EN_BIT]; // RL2 RL5
      end else if (s.enable) begin // RL3 RL4
        unique case (wsel)
          SBI_SEL_XFER: begin
            next_s.len = wd[SBI_LEN_LSB +: 3]; // RL7
            next_s.ack = wd[SBI_ACK_BIT];
            next_s.sck_hi = wd[SBI_SCK_LSB +: 2];
            next_s.sck0 = wd[SBI_SOFT_RESET_MONITOR_BIT];
          end
          SBI_SEL_DATA: begin
            // Buffer is locked while a transfer is on the link
            if ((s.xfer == SBI_XF_IDLE) && (s.mode != SBI_MODE_PORT) &&
                (s.mode != SBI_MODE_RSVD)) begin // RL1
              next_s.tx_data = wd[7:0];
              next_s.start_toggle = ~s.start_toggle;
              next_s.xfer = SBI_XF_BUSY;
            end
          end
          SBI_SEL_ADDR: begin
            next_s.own_addr = wd[7:0];
          end
          SBI_SEL_CMDSTAT: begin
            next_s.mst = wd[SBI_MST_BIT];
            next_s.trx = wd[SBI_TRX_BIT];
            if (wd[SBI_MODE_LSB +: 2] != SBI_MODE_RSVD) begin // RL9
              next_s.mode = wd[SBI_MODE_LSB +: 2];
            end
            if (wd[SBI_MODE_LSB +: 2] == SBI_MODE_SIO) begin
              next_s.sck0 = 1'b0; // RL8
            end
          end
          SBI_SEL_BAUD: begin
            next_s.baud = wd[7:0];
          end
          // Unmapped offsets and the enable itself change nothing here
          default: begin
          end
        endcase
      end
    end

    // Read channel: one read at a time, answer the cycle after it is taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = sbi_read(s, s_axi_araddr);
      next_s.rresp = sbi_mapped(s_axi_araddr) ? SBI_RESP_OKAY : SBI_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.xfer <= SBI_XF_IDLE;
      s.mode <= SBI_MODE_PORT; // RL9
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign interface_clock_run = s.enable; // RL4
endmodule : sbi_regs

/* File: verification/sbi_regs_checker.sv */
module sbi_regs_checker import sbi_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic serial_active,
  input wire logic interface_clock_run
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Helpers
  logic [3:0] act_cnt;
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) act_cnt <= 4'h0;
    else act_cnt <= serial_active ? act_cnt + 4'h1 : 4'h0;
  end
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  // ==========================================================
  // Assertions
  a_write_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
  // The answer lands two edges after the take: one to park, one to perform
  a_bad_strobe: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_take ##0 s_axi_wstrb != 4'hf |-> ##2 s_axi_bresp == SBI_RESP_SLVERR)
    else $error("partial write accepted");
  a_enable_run: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_take ##0 (s_axi_awaddr == SBI_OFF_ENABLE && s_axi_wstrb == 4'hf)
    |-> ##2 interface_clock_run == $past(s_axi_wdata[SBI_EN_BIT], 2))
    else $error("clock run differs from enable");
  a_read_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |=> s_axi_rresp == SBI_RESP_SLVERR && s_axi_rdata == SBI_ZERO_WORD)
    else $error("unmapped read not refused");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("reserved bits set");
  a_disabled_read: assert property (@(posedge mclk) disable iff (!reset_n)
    !interface_clock_run && s_axi_arvalid && s_axi_arready && s_axi_araddr == SBI_OFF_BAUD
    |=> s_axi_rdata == SBI_ZERO_WORD) else $error("disabled register readable");
  a_active_enabled: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(serial_active) |-> interface_clock_run) else $error("link ran while disabled");
  a_clock_count: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(serial_active) |-> act_cnt inside {[4'h1:4'h9]}) else $error("bad clock count");
  c_write: cover property (@(posedge mclk) disable iff (!reset_n) wr_take);
  c_refused: cover property (@(posedge mclk) disable iff (!reset_n)
    s_axi_rvalid && s_axi_rresp == SBI_RESP_SLVERR);
  c_frame: cover property (@(posedge link_clk) disable iff (!reset_n) $fell(serial_active));
endmodule : sbi_regs_checker

bind sbi_regs sbi_regs_checker #(.ADDR_W(ADDR_W)) i_sbi_regs_checker (.*);

/* File: verification/sbi_peer.sv */
module sbi_peer (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic serial_active,
  input wire logic serial_out,
  output logic serial_in,
  output logic [8:0] seen,
  output logic [3:0] n_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pattern;
  // Sample mid-bit, away from the edge that moves the line
  always @(negedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 9'h000;
      n_bits <= 4'h0;
      serial_in <= 1'b0;
      pattern <= 8'h5a;
    end else if (serial_active) begin
      seen <= {seen[7:0], serial_out};
      n_bits <= n_bits + 4'h1;
      serial_in <= pattern[7];
      pattern <= {pattern[6:0], pattern[7]};
    end else begin
      n_bits <= 4'h0;
      seen <= 9'h000;
      // Outside frames the line keeps moving so stale bits cannot pass
      serial_in <= ~serial_in;
    end
  end
endmodule : sbi_peer

/* File: verification/sbi_regs_test.sv */
module sbi_regs_test import sbi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OKR = SBI_RESP_OKAY;
  logic mclk = 0, link_clk = 0, reset_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, got, keep;
  logic [3:0] s_axi_wstrb = 0, n_bits;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serial_in, serial_out, serial_active, interface_clock_run;
  logic [8:0] seen;
  logic [34:0] er[$];
  logic [1:0] eb[$];
  logic [12:0] es[$];
  int miscompares = 0, n_compared = 0, cycles = 0, seed = 32'hdf1b;

  initial forever #5 mclk = ~mclk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  sbi_regs i_sbi_regs (.*);
  sbi_peer i_sbi_peer (.*);

  // ==========================================================
  // Checking
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge mclk) begin
    logic [34:0] e;
    if (s_axi_bvalid && s_axi_bready && eb.size() > 0) cmp(s_axi_bresp, eb.pop_front());
    if (s_axi_rvalid && s_axi_rready && er.size() > 0) begin
      e = er.pop_front();
      if (e[34]) cmp({s_axi_rresp, s_axi_rdata}, e[33:0]);
    end
    cycles++;
    // Generous ceiling: the whole run needs a few hundred cycles
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end

  always @(negedge serial_active) begin
    logic [12:0] e;
    if (es.size() > 0) begin
      e = es.pop_front();
      cmp(n_bits, e[11:8] + e[12]);
      cmp((seen >> e[12]) & ((9'h001 << e[11:8]) - 9'h001), e[7:0]);
    end
  end

  // ==========================================================
  // Bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] r);
    eb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                          input logic c, output logic [31:0] g);
    er.push_back({c, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    g = s_axi_rdata;
  endtask : axi_read

  // ==========================================================
  // Sequence
  initial begin
    int n;
    logic [7:0] a;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    axi_read(SBI_OFF_ENABLE, 32'h0000_0000, OKR, 1, got);
    axi_write(SBI_OFF_BAUD, 32'h0000_00ff, 4'hf, OKR);
    axi_read(SBI_OFF_BAUD, 32'h0000_0000, OKR, 1, got);
    cmp(interface_clock_run, 1'b0);
    axi_write(SBI_OFF_ENABLE, 32'hffff_ffff, 4'hf, OKR);
    axi_read(SBI_OFF_ENABLE, 32'h0000_0080, OKR, 1, got);
    cmp(interface_clock_run, 1'b1);
    axi_read(SBI_OFF_XFER, 32'h0000_0009, OKR, 1, got);
    for (int i = 0; i < 2; i++) begin
      a = i ? SBI_OFF_BAUD : SBI_OFF_ADDR;
      keep = $random(seed);
      axi_write(a, keep, 4'hf, OKR);
      axi_write(a, ~keep, 4'h3, SBI_RESP_SLVERR);
      axi_read(a, {24'h00_0000, keep[7:0]}, OKR, 1, got);
    end
    axi_write(8'h18, 32'h0000_0000, 4'hf, SBI_RESP_SLVERR);
    axi_read(8'h18, 32'h0000_0000, SBI_RESP_SLVERR, 1, got);
    for (int m = 0; m < 4; m++) begin
      axi_write(SBI_OFF_CMDSTAT, 32'(m << 2), 4'hf, OKR);
      axi_read(SBI_OFF_CMDSTAT, m == 3 ? 32'h0000_0008 : 32'(m << 2), OKR, 1, got);
    end
    axi_write(SBI_OFF_CMDSTAT, 32'h0000_0004, 4'hf, OKR);
    for (int l = 0; l < 5; l++) begin
      n = l ? l : 8;
      axi_write(SBI_OFF_XFER, {24'h00_0000, 3'(l), l[0], 4'h0}, 4'hf, OKR);
      axi_read(SBI_OFF_XFER, {24'h00_0000, 3'(l), l[0], 4'h9}, OKR, 1, got);
      es.push_back({l[0], 4'(n), 8'(8'ha5 >> (8 - n))});
      axi_write(SBI_OFF_DATA, 32'h0000_00a5, 4'hf, OKR);
      @(negedge serial_active);
      @(posedge mclk);
      do axi_read(SBI_OFF_CMDSTAT, 32'h0000_0000, OKR, 0, got);
      while (got[SBI_BUSY_BIT] !== 1'b0);
    end
    cmp(es.size(), 0);
    axi_write(SBI_OFF_ENABLE, 32'h0000_0000, 4'hf, OKR);
    cmp(interface_clock_run, 1'b0);
    axi_read(SBI_OFF_ADDR, 32'h0000_0000, OKR, 1, got);
    axi_write(SBI_OFF_ENABLE, 32'h0000_0080, 4'hf, OKR);
    axi_read(SBI_OFF_BAUD, {24'h00_0000, keep[7:0]}, OKR, 1, got);
    give_verdict;
  end
endmodule : sbi_regs_test
